// ==== sas_pkg.sv ====
// Purpose: shared constants for the successive-approximation sequencer
// Assumes: 100 MHz core clock; byte-wide register ports
// Notes:   timing counts come from the conversion-time select field
package sas_pkg;
  localparam logic [7:0] SAS_MODE_RST     = 8'h01;
  localparam logic [7:0] SAS_PINSEL_RST   = 8'h00;
  localparam logic [7:0] SAS_EDGE_RST     = 8'h00;
  localparam int         SAS_RUN_BIT      = 7;
  localparam int         SAS_TRG_BIT      = 6;
  localparam int         SAS_FR_HI        = 5;
  localparam int         SAS_FR_LO        = 4;
  localparam int         SAS_CH_HI        = 3;
  localparam int         SAS_CH_LO        = 1;
  localparam int         SAS_HALVE_BIT    = 0;
  localparam logic [3:0] SAS_PIN_MAX      = 4'h8;
  localparam int         SAS_NBITS        = 8;
  // clocks per conversion for each time setting; a conversion is split
  // into one sampling slot and eight trial slots of equal length
  localparam int         SAS_CONV_160     = 160;
  localparam int         SAS_CONV_80      = 80;
  localparam int         SAS_CONV_100     = 100;
  localparam int         SAS_CONV_200     = 200;
  localparam int         SAS_SLOTS        = SAS_NBITS + 1;
  localparam logic [7:0] SAS_SLOT_160     = 8'(SAS_CONV_160 / SAS_SLOTS);
  localparam logic [7:0] SAS_SLOT_80      = 8'(SAS_CONV_80 / SAS_SLOTS);
  localparam logic [7:0] SAS_SLOT_100     = 8'(SAS_CONV_100 / SAS_SLOTS);
  localparam logic [7:0] SAS_SLOT_200     = 8'(SAS_CONV_200 / SAS_SLOTS);
  // comparator settling: decision taken at slot count slot length minus this value; 01h decides on the slot-end edge
  localparam logic [7:0] SAS_SETTLE_LEAD  = 8'h01;
  typedef enum logic [2:0] {
    SAS_IDLE   = 3'b001,
    SAS_SAMPLE = 3'b010,
    SAS_TRIAL  = 3'b100
  } sas_state_e;
endpackage : sas_pkg

// ==== sas_sequencer.sv ====
// Purpose: control of an 8-bit successive-approximation converter
// Assumes: all inputs synchronous to core_clk_i; comparator settles in a slot
// Notes:   analog comparator, ladder and sample-hold sit outside
//
// Overview of operation
// [R1] software sets the analog pin count before choosing a channel among them
// [R2] pull-ups stay off on analog pins whatever the pull-up option bit says
// [R3] pin count N makes pins 0..N-1 analog; above eight prohibited; top bits zero
// [R4] each conversion samples a fixed time, then holds until it completes
// [R5] after sampling, msb trial set and ladder tap at half reference
// [R6] per bit keep one if input at or above tap, then set next bit
// [R7] after eight bits copy trial value to result and pulse done request
// [R8] in software mode conversions repeat until software clears the run bit
// [R9] mode write during conversion reinitialises; run bit set in software mode restarts it
// [R10] result register has no reset value
// [R11] result rounds input ratio times 256 to nearest step
// [R12] trigger mode with run set waits; each trigger starts one conversion
// [R13] trigger mode idles after a conversion until a fresh trigger
// [R14] trigger mode write with run set aborts and waits for new trigger
// [R15] write with run cleared halts conversion at once
// [R16] software mode starts at once and back to back repeats
// [R17] software mode write with run set restarts with new settings
// [R18] trigger edge chosen by edge mode register, reset zero
// [R19] mode register: run bit 7, trigger bit 6, channel bits 3..1, reset 01h
// [R20] software picks a setting of 80 to 200 clocks per conversion; truncated slots give 72 to 198 clocks
// [R21] mode writes do not clear the done flag
// [R22] comparator sampled once per trial at fixed count after tap change
`timescale 1ns/1ps
module sas_sequencer (
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       clk_en_i,
  input  wire logic       mode_wr_i,
  input  wire logic [7:0] mode_wdata_i,
  output logic      [7:0] mode_rdata_o,
  input  wire logic       pinsel_wr_i,
  input  wire logic [7:0] pinsel_wdata_i,
  output logic      [7:0] pinsel_rdata_o,
  input  wire logic       edge_wr_i,
  input  wire logic [7:0] edge_wdata_i,
  output logic      [7:0] edge_rdata_o,
  output logic      [7:0] result_o,
  input  wire logic       pullup_opt_i,
  input  wire logic       external_trigger_input_i,
  input  wire logic       comp_ge_i,
  output logic      [7:0] analog_en_o,
  output logic      [7:0] pullup_en_o,
  output logic      [2:0] channel_o,
  output logic            sample_o,
  output logic            hold_o,
  output logic      [7:0] ladder_tap_o,
  output logic            busy_o,
  output logic            conversion_done_irq_o
);
  import sas_pkg::*;

  logic [7:0] conversion_mode_reg_r;
  logic [3:0] pin_count_r;
  logic [1:0] edge_sel_r;
  logic [7:0] bit_trial_reg_r;
  logic [7:0] conversion_result_reg_r;
  logic [7:0] slot_cnt_r;
  logic [2:0] bit_idx_r;
  logic       trig_d_r;
  logic       done_r;
  sas_state_e state_r;

  logic       run;
  logic       trg_mode;
  logic       trig_edge;
  logic [7:0] slot_len;
  logic       slot_end;
  logic       decide;
  logic       start_now;

  // thermometer decode of the pin count, reused for pull-up gating
  function automatic logic [7:0] pin_mask(input logic [3:0] n);
    logic [7:0] m;
    m = '0;
    for (int i = 0; i < 8; i++) begin
      m[i] = (4'(i) < n);
    end
    return m;
  endfunction : pin_mask

  function automatic logic [7:0] slot_of(input logic [7:0] mode);
    logic [2:0] sel;
    sel = {mode[SAS_FR_HI], mode[SAS_FR_LO], mode[SAS_HALVE_BIT]};
    unique case (sel)
      3'b001:  return SAS_SLOT_160;
      3'b011:  return SAS_SLOT_80;
      3'b100:  return SAS_SLOT_100;
      3'b101:  return SAS_SLOT_200;
      // prohibited codes fall back to the slowest setting
      default: return SAS_SLOT_200;
    endcase
  endfunction : slot_of

  assign run      = conversion_mode_reg_r[SAS_RUN_BIT];
  assign trg_mode = conversion_mode_reg_r[SAS_TRG_BIT];
  assign slot_len = slot_of(conversion_mode_reg_r); // R22
  assign slot_end = (slot_cnt_r == slot_len - 8'h01);
  assign decide   = (state_r == SAS_TRIAL) && (slot_cnt_r == slot_len - 8'h01 - SAS_SETTLE_LEAD + 8'h01); // R22

  // trigger edge select: 00 falling, 01 rising, 1x both edges
  always_comb begin
    unique case (edge_sel_r)
      2'b00:   trig_edge = trig_d_r & ~external_trigger_input_i;
      2'b01:   trig_edge = ~trig_d_r & external_trigger_input_i;
      default: trig_edge = trig_d_r ^ external_trigger_input_i;
    endcase
  end // R18

  assign start_now = run && (!trg_mode || trig_edge); // R12 R16

  // mode register, reset 01h
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conversion_mode_reg_r <= SAS_MODE_RST; // R19
    end else if (clk_en_i && mode_wr_i) begin
      conversion_mode_reg_r <= mode_wdata_i; // R19
    end
  end

  // pin-select register; prohibited counts above eight are ignored
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_count_r <= SAS_PINSEL_RST[3:0];
    end else if (clk_en_i && pinsel_wr_i && pinsel_wdata_i[3:0] <= SAS_PIN_MAX) begin
      pin_count_r <= pinsel_wdata_i[3:0]; // R3
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      edge_sel_r <= SAS_EDGE_RST[1:0]; // R18
      trig_d_r   <= 1'b0;
    end else if (clk_en_i) begin
      if (edge_wr_i) begin
        edge_sel_r <= edge_wdata_i[1:0];
      end
      trig_d_r <= external_trigger_input_i;
    end
  end

  // sequencer; a mode write always wins and reinitialises the conversion
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r    <= SAS_IDLE;
      slot_cnt_r <= 8'h00;
      bit_idx_r  <= 3'h7;
    end else if (clk_en_i) begin
      if (mode_wr_i) begin
        // software mode with run set restarts at once; trigger mode waits
        slot_cnt_r <= 8'h00;
        bit_idx_r  <= 3'h7;
        if (mode_wdata_i[SAS_RUN_BIT] && !mode_wdata_i[SAS_TRG_BIT]) begin
          state_r <= SAS_SAMPLE; // R9 R17
        end else begin
          state_r <= SAS_IDLE; // R14 R15
        end
      end else begin
        unique case (state_r)
          SAS_IDLE: begin
            if (start_now) begin
              state_r    <= SAS_SAMPLE; // R12 R16
              slot_cnt_r <= 8'h00;
            end
          end
          SAS_SAMPLE: begin
            if (slot_end) begin
              state_r    <= SAS_TRIAL; // R4
              slot_cnt_r <= 8'h00;
              bit_idx_r  <= 3'h7;
            end else begin
              slot_cnt_r <= slot_cnt_r + 8'h01;
            end
          end
          SAS_TRIAL: begin
            if (slot_end) begin
              slot_cnt_r <= 8'h00;
              if (bit_idx_r == 3'h0) begin
                // back-to-back in software mode, idle in trigger mode
                state_r <= (run && !trg_mode) ? SAS_SAMPLE : SAS_IDLE; // R8 R13 R16
              end else begin
                bit_idx_r <= bit_idx_r - 3'h1; // R6
              end
            end else begin
              slot_cnt_r <= slot_cnt_r + 8'h01;
            end
          end
        endcase
      end
    end
  end

  // trial register: current bit shown as one while it is being tried
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_trial_reg_r <= 8'h00;
    end else if (clk_en_i) begin
      if (mode_wr_i || (state_r == SAS_SAMPLE && slot_end)) begin
        bit_trial_reg_r <= 8'h80; // R5
      end else if (decide) begin
        // bit stays one when input is at or above the tap
        bit_trial_reg_r[bit_idx_r] <= comp_ge_i; // R6 R11
        if (bit_idx_r != 3'h0) begin
          bit_trial_reg_r[bit_idx_r - 3'h1] <= 1'b1; // R6
        end
      end
    end
  end

  // result register deliberately has no reset
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i && !mode_wr_i && state_r == SAS_TRIAL && slot_end && bit_idx_r == 3'h0) begin
      // bit 0 is decided on this same edge, so take it straight from the comparator
      conversion_result_reg_r <= {bit_trial_reg_r[7:1], comp_ge_i}; // R7 R10
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_r <= 1'b0;
    end else if (clk_en_i) begin
      // mode writes leave the interrupt flag elsewhere untouched
      done_r <= !mode_wr_i && state_r == SAS_TRIAL && slot_end && bit_idx_r == 3'h0; // R7 R21
    end else begin
      done_r <= 1'b0;
    end
  end

  // tap is the trial value; the ladder's half-lsb offset gives the rounding
  assign ladder_tap_o          = bit_trial_reg_r; // R5 R11
  assign mode_rdata_o          = conversion_mode_reg_r;
  assign pinsel_rdata_o        = {4'h0, pin_count_r}; // R3
  assign edge_rdata_o          = {6'h00, edge_sel_r};
  assign result_o              = conversion_result_reg_r;
  assign analog_en_o           = pin_mask(pin_count_r); // R3
  assign pullup_en_o           = {8{pullup_opt_i}} & ~pin_mask(pin_count_r); // R2
  assign channel_o             = conversion_mode_reg_r[SAS_CH_HI:SAS_CH_LO]; // R19
  assign sample_o              = (state_r == SAS_SAMPLE); // R4
  assign hold_o                = (state_r == SAS_TRIAL); // R4
  assign busy_o                = (state_r != SAS_IDLE);
  assign conversion_done_irq_o = done_r;

  // assertions
  a_pullup_off_analog: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R2
    (pullup_en_o & analog_en_o) == 8'h00) else $error("pull-up on analog pin");
  a_pin_top_zero: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R3
    pinsel_rdata_o[7:4] == 4'h0) else $error("pin select top bits not zero");
  a_msb_after_sample: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R5
    clk_en_i && !mode_wr_i && state_r == SAS_SAMPLE && slot_end |=> ladder_tap_o == 8'h80 && hold_o)
    else $error("msb trial not set after sampling");
  a_result_copied: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R7
    $rose(conversion_done_irq_o) |-> result_o == ladder_tap_o)
    else $error("result not copied with done");
  a_stop_halts: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R15
    clk_en_i && mode_wr_i && !mode_wdata_i[SAS_RUN_BIT] |=> !busy_o)
    else $error("run clear did not halt");
  a_trg_write_waits: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R14
    clk_en_i && mode_wr_i && mode_wdata_i[SAS_TRG_BIT] |=> !busy_o)
    else $error("trigger mode write did not abort");
  a_sw_write_restarts: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R17
    clk_en_i && mode_wr_i && mode_wdata_i[7:6] == 2'b10 |=> sample_o && slot_cnt_r == 8'h00)
    else $error("software restart missing");
  a_trg_idle_after: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R13
    conversion_done_irq_o && trg_mode |-> !busy_o) else $error("trigger mode kept converting");
  a_sw_back_to_back: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R16
    conversion_done_irq_o && run && !trg_mode && !$past(mode_wr_i) |-> sample_o)
    else $error("software mode did not repeat");
  a_mode_reset_val: assert property (@(posedge core_clk_i) // R19
    !nrst_i |=> !nrst_i || conversion_mode_reg_r == SAS_MODE_RST || $past(mode_wr_i))
    else $error("mode reset value wrong");

  c_trig_start:   cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    trg_mode && run && trig_edge && !busy_o ##1 sample_o);
  c_done:         cover property (@(posedge core_clk_i) disable iff (!nrst_i) $rose(conversion_done_irq_o));
  c_abort:        cover property (@(posedge core_clk_i) disable iff (!nrst_i) hold_o && mode_wr_i);
  c_full_pins:    cover property (@(posedge core_clk_i) disable iff (!nrst_i) analog_en_o == 8'hff);
endmodule : sas_sequencer

// ==== sas_comp_model.sv ====
// Purpose: comparator, ladder and sample-hold model facing the sequencer
// Assumes: inputs in units of reference/512 per channel
// Notes:   output is junk outside trials, as a floating comparator would be
`timescale 1ns/1ps
module sas_comp_model (
  input  wire logic            core_clk_i,
  input  wire logic            sample_i,
  input  wire logic            hold_i,
  input  wire logic [2:0]      channel_i,
  input  wire logic [7:0]      tap_i,
  input  wire logic [7:0][9:0] vin_i,
  output logic                 comp_ge_o
);
  logic [9:0] held_r;
  logic       junk_r;
  initial begin
    held_r = '0;
    junk_r = 1'b0;
  end
  always @(posedge core_clk_i) begin
    junk_r <= ~junk_r;
    if (sample_i) held_r <= vin_i[channel_i];
  end
  // tap sits half a step low so the code rounds to nearest
  assign comp_ge_o = hold_i ? (({1'b0, held_r} + 11'd1) >= {2'b0, tap_i, 1'b0}) : junk_r;
endmodule : sas_comp_model

// ==== testbench.sv ====
// Purpose: self-checking bench for the approximation sequencer
// Assumes: fastest time code, slot of 8 clocks, 72 clocks a conversion
// Notes:   inputs change on the falling edge only
`timescale 1ns/1ps
module testbench;
  import sas_pkg::*;
  logic clk, nrst, mwr, pwr, ewr, popt, trig;
  logic [7:0] mwd, pwd, ewd, mrd, prd, erd, res, aen, puen, tap;
  logic [2:0] ch;
  logic smp, hld, busy, irq, ge;
  logic [7:0][9:0] vin;
  int errors, checked, n;
  sas_sequencer dut (.core_clk_i(clk), .nrst_i(nrst), .clk_en_i(1'b1), .mode_wr_i(mwr),
    .mode_wdata_i(mwd), .mode_rdata_o(mrd), .pinsel_wr_i(pwr), .pinsel_wdata_i(pwd),
    .pinsel_rdata_o(prd), .edge_wr_i(ewr), .edge_wdata_i(ewd), .edge_rdata_o(erd),
    .result_o(res), .pullup_opt_i(popt), .external_trigger_input_i(trig), .comp_ge_i(ge),
    .analog_en_o(aen), .pullup_en_o(puen), .channel_o(ch), .sample_o(smp), .hold_o(hld),
    .ladder_tap_o(tap), .busy_o(busy), .conversion_done_irq_o(irq));
  sas_comp_model cmp (.core_clk_i(clk), .sample_i(smp), .hold_i(hld), .channel_i(ch),
    .tap_i(tap), .vin_i(vin), .comp_ge_o(ge));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [7:0] expc(input int v);
    return (v >= 510) ? 8'hff : 8'((v + 1) / 2);
  endfunction : expc
  task automatic wr(input int sel, input logic [7:0] d);
    @(negedge clk);
    mwr = (sel == 0);
    pwr = (sel == 1);
    ewr = (sel == 2);
    mwd = d;
    pwd = d;
    ewd = d;
    @(negedge clk);
    {mwr, pwr, ewr} = 3'b000;
  endtask : wr
  task automatic wait_done(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (irq !== 1'b1 && k < 2000);
    chk(8'(k < 2000), 8'h01);
  endtask : wait_done
  task automatic quiet(input int cyc);
    int hits;
    hits = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (irq === 1'b1) hits++;
    end
    chk(8'(hits), 8'h00);
  endtask : quiet
  task automatic t_pins();
    popt = 1'b1;
    for (int i = 0; i <= 8; i++) begin
      wr(1, 8'(i));
      chk(prd, 8'(i));
      chk(aen, 8'((16'h1 << i) - 1));
      chk(puen, ~8'((16'h1 << i) - 1));
    end
    wr(1, 8'h09);
    chk(prd, 8'h08);
    wr(1, 8'hf5);
    chk(prd, 8'h05);
    wr(1, 8'h08);
    $display("test pins done");
  endtask : t_pins
  task automatic t_soft();
    for (int c = 0; c < 8; c++) begin
      wr(0, 8'h91 | 8'(c << 1));
      chk(mrd, 8'h91 | 8'(c << 1));
      wait_done(n);
      chk(res, expc(vin[c]));
      chk({5'h0, ch}, 8'(c));
    end
    wait_done(n);
    chk(8'(n <= 80), 8'h01);
    chk(res, expc(vin[7]));
    repeat (30) @(negedge clk);
    wr(0, 8'h95);
    wait_done(n);
    chk(8'(n >= 68), 8'h01);
    chk(res, expc(vin[2]));
    $display("test software start done");
  endtask : t_soft
  task automatic t_stop();
    repeat (20) @(negedge clk);
    wr(0, 8'h13);
    chk({7'h0, busy}, 8'h00);
    quiet(200);
    chk(mrd, 8'h13);
    $display("test stop done");
  endtask : t_stop
  task automatic t_trig();
    wr(2, 8'h01);
    chk(erd, 8'h01);
    wr(0, 8'hd7);
    quiet(100);
    chk({7'h0, busy}, 8'h00);
    trig = 1'b1;
    wait_done(n);
    chk(res, expc(vin[3]));
    quiet(200);
    chk({7'h0, busy}, 8'h00);
    trig = 1'b0;
    @(negedge clk);
    trig = 1'b1;
    repeat (20) @(negedge clk);
    chk({7'h0, busy}, 8'h01);
    wr(0, 8'hd7);
    @(negedge clk);
    chk({7'h0, busy}, 8'h00);
    quiet(100);
    trig = 1'b0;
    @(negedge clk);
    trig = 1'b1;
    wait_done(n);
    chk(8'(n >= 70), 8'h01);
    $display("test trigger start done");
  endtask : t_trig
  task automatic finish_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  initial begin
    #300us;
    errors++;
    finish_test();
  end
  initial begin
    {nrst, mwr, pwr, ewr, popt, trig} = 6'b0;
    {mwd, pwd, ewd} = '0;
    for (int c = 0; c < 8; c++) vin[c] = 10'(c * 70 + 3);
    vin[0] = 10'd0;
    vin[7] = 10'd511;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    chk(mrd, SAS_MODE_RST);
    chk(prd, 8'h00);
    chk(erd, 8'h00);
    chk({6'h0, busy, irq}, 8'h00);
    t_pins();
    t_soft();
    t_stop();
    t_trig();
    finish_test();
  end
endmodule : testbench
